// >>> logic/amd_pkg.sv
// Constants and mode codes for the addressing-mode decoder.
// Assumes the core decodes the opcode into a base mode code.
`default_nettype none
package amd_pkg;
    // ------------------------------------------------------------
    // Prefix bytes, interrupt mask levels, page-zero base and opcode length
    // ------------------------------------------------------------
    localparam logic [7:0] PFX_SECOND_IDX = 8'h90;
    localparam logic [7:0] PFX_IND_SECOND = 8'h91;
    localparam logic [7:0] PFX_INDIRECT = 8'h92;
    localparam logic [1:0] MASK_SET_LVL = 2'h3;
    localparam logic [1:0] MASK_CLR_LVL = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h3;
    localparam logic [15:0] PAGE_ZERO = 16'h0000;
    localparam logic [2:0] OPCODE_LEN = 3'h1;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MD_INH = 4'h0,
        MD_IMM = 4'h1,
        MD_DIR_S = 4'h2,
        MD_DIR_L = 4'h3,
        MD_IDX_0 = 4'h4,
        MD_IDX_S = 4'h5,
        MD_IDX_L = 4'h6,
        MD_IND_S = 4'h7,
        MD_IND_L = 4'h8,
        MD_IIX_S = 4'h9,
        MD_IIX_L = 4'hA,
        MD_REL_D = 4'hB,
        MD_REL_I = 4'hC
    } amd_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPND = 3'h1,
        ST_PTR = 3'h2,
        ST_DONE = 3'h3
    } amd_state_e;
endpackage
`default_nettype wire

// >>> logic/amd_decoder.sv
// Operand fetch and effective-address former for an 8-bit core.
// Assumes a same-clock memory port answering with a one-cycle ack.
`default_nettype none

// Function
// - Inherent instructions are one byte; no operand bytes fetched.
// - Immediate: opcode then one byte used directly as operand value.
// - Short direct: one address byte, range 00 to FF.
// - Long direct: two address bytes reach the whole 64K space.
// - Indexed address is unsigned index plus offset, no sign extension.
// - Indexed without offset: no byte follows, index alone is address.
// - Short indexed: one offset byte plus index, range 00 to 1FE.
// - Long indexed: two offset bytes plus index over 64K.
// - Short indirect: byte pointer read from byte address is the effective address.
// - Long indirect: word pointer read from byte address, 64K range.
// - Indirect indexed: pointer from memory plus index, unsigned.
// - Short indirect indexed: byte address, byte pointer, 00 to 1FE.
// - Short direct and short indirect reach page zero only, fewer bytes.
// - Read-modify-write instructions accept short forms only.
// - Long variants reach the full 64K space.
// - Mask-set inherent instruction puts mask at level 3.
// - Mask-clear inherent instruction puts mask at level 0.
// - Relative target is PC plus signed 8-bit offset.
// - Prefix 90 selects the second index register.
// - Prefix 92 turns direct, offset X-indexed and relative forms into indirect ones.
module amd_decoder (
    // Clock and reset
    input wire logic refClk,
    input wire logic arst_n,
    // Core request
    input wire logic start,
    input wire logic [3:0] baseMode,
    input wire logic [7:0] prefixByte,
    input wire logic hasPrefix,
    input wire logic rmwOp,
    input wire logic interruptMaskSetOp,
    input wire logic interruptMaskClearOp,
    input wire logic [15:0] pcIn,
    input wire logic [7:0] idxX,
    input wire logic [7:0] idxY,
    // Memory port
    output logic memReq,
    output logic [15:0] memAddr,
    input wire logic memAck,
    input wire logic [7:0] memRdata,
    // Results
    output logic done,
    output logic modeError,
    output logic [3:0] effMode,
    output logic [15:0] effAddr,
    output logic [7:0] immValue,
    output logic isImmediate,
    output logic [2:0] instrLen,
    output logic [1:0] intMask
);
    // ------------------------------------------------------------
    // Mode helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] opndBytes(input logic [3:0] m);
        unique case (m)
            amd_pkg::MD_INH, amd_pkg::MD_IDX_0: opndBytes = 2'h0;
            amd_pkg::MD_DIR_L, amd_pkg::MD_IDX_L: opndBytes = 2'h2;
            default: opndBytes = 2'h1;
        endcase
    endfunction

    function automatic logic isLong(input logic [3:0] m);
        isLong = (m == amd_pkg::MD_DIR_L) || (m == amd_pkg::MD_IDX_L) ||
            (m == amd_pkg::MD_IND_L) || (m == amd_pkg::MD_IIX_L);
    endfunction

    function automatic logic isIndexed(input logic [3:0] m);
        isIndexed = (m == amd_pkg::MD_IDX_0) || (m == amd_pkg::MD_IDX_S) ||
            (m == amd_pkg::MD_IDX_L) || (m == amd_pkg::MD_IIX_S) ||
            (m == amd_pkg::MD_IIX_L);
    endfunction

    // ------------------------------------------------------------
    // Prefix translation
    // ------------------------------------------------------------
    logic [3:0] modeX;
    logic useY;
    always_comb begin
        modeX = baseMode;
        useY = 1'b0;
        if (hasPrefix && prefixByte == amd_pkg::PFX_SECOND_IDX) begin
            useY = 1'b1;
        end
        if (hasPrefix && (prefixByte == amd_pkg::PFX_INDIRECT ||
                prefixByte == amd_pkg::PFX_IND_SECOND)) begin
            useY = (prefixByte == amd_pkg::PFX_IND_SECOND);
            unique case (baseMode)
                amd_pkg::MD_DIR_S: modeX = amd_pkg::MD_IND_S;
                amd_pkg::MD_DIR_L: modeX = amd_pkg::MD_IND_L;
                amd_pkg::MD_IDX_S: modeX = amd_pkg::MD_IIX_S;
                amd_pkg::MD_IDX_L: modeX = amd_pkg::MD_IIX_L;
                amd_pkg::MD_REL_D: modeX = amd_pkg::MD_REL_I;
                default: modeX = baseMode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    amd_pkg::amd_state_e state_reg;
    logic [3:0] mode_reg;
    logic [7:0] idx_reg;
    logic [15:0] pc_reg;
    logic [15:0] fetchAddr_reg;
    logic [1:0] left_reg;
    logic [15:0] word_reg;
    logic memReq_reg;
    logic [15:0] memAddr_reg;
    logic done_reg;
    logic modeError_reg;
    logic [15:0] effAddr_reg;
    logic [7:0] imm_reg;
    logic isImm_reg;
    logic [2:0] len_reg;
    logic [1:0] intMask_reg;

    // Pointer width: word for long indirect forms
    logic ptrWord;
    assign ptrWord = isLong(mode_reg);

    // Final address from collected operand or pointer
    logic [15:0] effNext;
    always_comb begin
        effNext = word_reg;
        unique case (mode_reg)
            amd_pkg::MD_IDX_0:
                effNext = {8'h00, idx_reg};
            amd_pkg::MD_IDX_S, amd_pkg::MD_IIX_S:
                // Nine-bit sum, carry lands in bit 8
                effNext = {7'h00, {1'b0, word_reg[7:0]} +
                    {1'b0, idx_reg}};
            amd_pkg::MD_IDX_L, amd_pkg::MD_IIX_L:
                effNext = word_reg + {8'h00, idx_reg};
            amd_pkg::MD_DIR_S, amd_pkg::MD_IND_S:
                effNext = {amd_pkg::PAGE_ZERO[15:8],
                    word_reg[7:0]};
            amd_pkg::MD_REL_D, amd_pkg::MD_REL_I:
                effNext = pc_reg + {{8{word_reg[7]}}, word_reg[7:0]};
            default:
                effNext = word_reg;
        endcase
    end

    // Modes whose operand byte is a pointer address
    logic needPtr;
    assign needPtr = (mode_reg == amd_pkg::MD_IND_S) ||
        (mode_reg == amd_pkg::MD_IND_L) || (mode_reg == amd_pkg::MD_IIX_S) ||
        (mode_reg == amd_pkg::MD_IIX_L) || (mode_reg == amd_pkg::MD_REL_I);

    logic [2:0] lenNext;
    always_comb begin
        lenNext = amd_pkg::OPCODE_LEN + {1'b0, opndBytes(modeX)};
        if (modeX == amd_pkg::MD_IND_L || modeX == amd_pkg::MD_IIX_L) begin
            // Long indirect takes one pointer-address byte only
            lenNext = amd_pkg::OPCODE_LEN + 3'h1;
        end
        if (hasPrefix) begin
            lenNext = lenNext + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Fetch sequencer
    // ------------------------------------------------------------
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= amd_pkg::ST_IDLE;
            mode_reg <= amd_pkg::MD_INH;
            idx_reg <= 8'h00;
            pc_reg <= 16'h0000;
            fetchAddr_reg <= 16'h0000;
            left_reg <= 2'h0;
            word_reg <= 16'h0000;
            memReq_reg <= 1'b0;
            memAddr_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                amd_pkg::ST_IDLE: begin
                    if (start) begin
                        mode_reg <= modeX;
                        idx_reg <= useY ? idxY : idxX;
                        // Prefix sits before the opcode, so it is not counted
                        pc_reg <= pcIn + {13'h0000, lenNext} -
                            {15'h0000, hasPrefix};
                        word_reg <= 16'h0000;
                        if (isLong(modeX) && rmwOp) begin
                            state_reg <= amd_pkg::ST_DONE;
                        end else if (modeX == amd_pkg::MD_INH ||
                                modeX == amd_pkg::MD_IDX_0) begin
                            state_reg <= amd_pkg::ST_DONE;
                        end else begin
                            // Operand bytes sit right after the opcode
                            left_reg <= (modeX == amd_pkg::MD_IND_L ||
                                modeX == amd_pkg::MD_IIX_L) ? 2'h1 :
                                opndBytes(modeX);
                            memAddr_reg <= pcIn + 16'h0001;
                            fetchAddr_reg <= pcIn + 16'h0001;
                            memReq_reg <= 1'b1;
                            state_reg <= amd_pkg::ST_OPND;
                        end
                    end
                end
                amd_pkg::ST_OPND: begin
                    if (memAck) begin
                        word_reg <= {word_reg[7:0], memRdata};
                        if (left_reg == 2'h1) begin
                            if (needPtr) begin
                                // Pointer address is page zero
                                memAddr_reg <= {8'h00, memRdata};
                                fetchAddr_reg <= {8'h00, memRdata};
                                left_reg <= ptrWord ? 2'h2 : 2'h1;
                                word_reg <= 16'h0000;
                                state_reg <= amd_pkg::ST_PTR;
                            end else begin
                                memReq_reg <= 1'b0;
                                state_reg <= amd_pkg::ST_DONE;
                            end
                        end else begin
                            left_reg <= left_reg - 2'h1;
                            memAddr_reg <= fetchAddr_reg + 16'h0001;
                            fetchAddr_reg <= fetchAddr_reg + 16'h0001;
                        end
                    end
                end
                amd_pkg::ST_PTR: begin
                    if (memAck) begin
                        // High byte first, then the next address
                        word_reg <= {word_reg[7:0], memRdata};
                        if (left_reg == 2'h1) begin
                            memReq_reg <= 1'b0;
                            state_reg <= amd_pkg::ST_DONE;
                        end else begin
                            left_reg <= left_reg - 2'h1;
                            memAddr_reg <= fetchAddr_reg + 16'h0001;
                            fetchAddr_reg <= fetchAddr_reg + 16'h0001;
                        end
                    end
                end
                amd_pkg::ST_DONE: begin
                    state_reg <= amd_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= amd_pkg::ST_IDLE;
                    memReq_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            done_reg <= 1'b0;
            modeError_reg <= 1'b0;
            effAddr_reg <= 16'h0000;
            imm_reg <= 8'h00;
            isImm_reg <= 1'b0;
            len_reg <= 3'h0;
        end else begin
            done_reg <= (state_reg == amd_pkg::ST_DONE);
            if (state_reg == amd_pkg::ST_IDLE && start) begin
                len_reg <= lenNext;
                modeError_reg <= isLong(modeX) && rmwOp;
                isImm_reg <= (modeX == amd_pkg::MD_IMM);
            end
            if (state_reg == amd_pkg::ST_DONE) begin
                if (mode_reg == amd_pkg::MD_IMM) begin
                    imm_reg <= word_reg[7:0];
                    effAddr_reg <= 16'h0000;
                end else begin
                    effAddr_reg <= effNext;
                end
            end
        end
    end

    // Interrupt mask level held for the core
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            intMask_reg <= amd_pkg::MASK_RST;
        end else if (state_reg == amd_pkg::ST_IDLE && start &&
                modeX == amd_pkg::MD_INH) begin
            if (interruptMaskSetOp) begin
                intMask_reg <= amd_pkg::MASK_SET_LVL;
            end else if (interruptMaskClearOp) begin
                intMask_reg <= amd_pkg::MASK_CLR_LVL;
            end
        end
    end

    assign memReq = memReq_reg;
    assign memAddr = memAddr_reg;
    assign done = done_reg;
    assign modeError = modeError_reg;
    assign effMode = mode_reg;
    assign effAddr = effAddr_reg;
    assign immValue = imm_reg;
    assign isImmediate = isImm_reg;
    assign instrLen = len_reg;
    assign intMask = intMask_reg;
endmodule
`default_nettype wire

// >>> testbench/amd_asserts.sv
// Checker for the addressing-mode decoder, sees its ports only.
// Assumes one-cycle start pulses and a one-cycle memAck.
`default_nettype none
module amd_asserts (
    // Clock and reset
    input wire logic refClk,
    input wire logic arst_n,
    // Core request
    input wire logic start,
    input wire logic [3:0] baseMode,
    input wire logic hasPrefix,
    input wire logic rmwOp,
    input wire logic interruptMaskSetOp,
    input wire logic interruptMaskClearOp,
    input wire logic [15:0] pcIn,
    input wire logic [7:0] idxX,
    // Memory port
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    input wire logic memAck,
    // Results
    input wire logic done,
    input wire logic modeError,
    input wire logic [3:0] effMode,
    input wire logic [15:0] effAddr,
    input wire logic [2:0] instrLen,
    input wire logic [1:0] intMask
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge refClk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Request tracking
    // ----------------------------------------
    logic busyReg;
    logic take;
    logic noPfx;
    assign take = start && !busyReg && !done;
    assign noPfx = take && !hasPrefix;
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n)
            busyReg <= 1'b0;
        else if (take)
            busyReg <= 1'b1;
        else if (done)
            busyReg <= 1'b0;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_inh;
        noPfx && baseMode == amd_pkg::MD_INH
            |=> !memReq ##1 (done && instrLen == 3'h1);
    endproperty
    a_inh: assert property (p_inh)
        else $error("inherent op fetched or wrong length");
    property p_idx0;
        noPfx && baseMode == amd_pkg::MD_IDX_0
            |=> !memReq ##1 (done && effAddr == {8'h00, idxX});
    endproperty
    a_idx0: assert property (p_idx0)
        else $error("no-offset index address wrong");
    property p_fetch;
        noPfx && (baseMode == amd_pkg::MD_IMM ||
            baseMode == amd_pkg::MD_DIR_S)
            |=> memReq && memAddr == $past(pcIn) + 16'h0001;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("first operand fetch address wrong");
    property p_hold;
        memReq && !memAck |=> memReq && $stable(memAddr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read request dropped or moved before ack");
    property p_rmw;
        noPfx && rmwOp && baseMode inside {amd_pkg::MD_DIR_L,
            amd_pkg::MD_IDX_L, amd_pkg::MD_IND_L, amd_pkg::MD_IIX_L}
            |=> (!memReq)[*2] ##[0:2] (done && modeError);
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("long form with rmw not refused");
    property p_mset;
        done && effMode == amd_pkg::MD_INH && interruptMaskSetOp
            |-> ##[0:1] intMask == 2'h3;
    endproperty
    a_mset: assert property (p_mset)
        else $error("mask not set to level 3");
    property p_mclr;
        done && effMode == amd_pkg::MD_INH && !interruptMaskSetOp &&
            interruptMaskClearOp |-> ##[0:1] intMask == 2'h0;
    endproperty
    a_mclr: assert property (p_mclr)
        else $error("mask not cleared to level 0");
    property p_page0;
        done && !modeError && effMode inside {amd_pkg::MD_DIR_S,
            amd_pkg::MD_IDX_0, amd_pkg::MD_IND_S} |-> effAddr[15:8] == 8'h00;
    endproperty
    a_page0: assert property (p_page0)
        else $error("short form left page zero");
    property p_nine;
        done && !modeError && effMode inside {amd_pkg::MD_IDX_S,
            amd_pkg::MD_IIX_S} |-> effAddr <= 16'h01FE;
    endproperty
    a_nine: assert property (p_nine)
        else $error("short indexed sum beyond nine bits");
    c_iixl: cover property (take && baseMode == amd_pkg::MD_IIX_L);
    c_err: cover property (done && modeError);
    c_stall: cover property ((memReq && !memAck) [*3]);
endmodule
`default_nettype wire

// >>> testbench/amd_mem_model.sv
// Program and data memory answering the decoder's reads.
// Assumes requests are held until the one-cycle ack.
`default_nettype none
module amd_mem_model (
    // Clock and reset
    input wire logic refClk,
    input wire logic arst_n,
    // Stall select
    input wire logic slow,
    // Memory port
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    output logic memAck,
    output logic [7:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waitCnt;
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            waitCnt <= 2'h0;
            memAck <= 1'b0;
            memRdata <= 8'h00;
        end else if (memReq && !memAck && (!slow || waitCnt == 2'h3)) begin
            waitCnt <= 2'h0;
            memAck <= 1'b1;
            memRdata <= memAddr[7:0] ^ memAddr[15:8] ^ 8'hC3;
        end else begin
            memAck <= 1'b0;
            // Stale data must never pass for a fresh byte
            memRdata <= ~memRdata;
            waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the addressing-mode decoder.
// Assumes amd_mem_model and amd_asserts are compiled first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic refClk = 1'b0, arst_n = 1'b0, start = 1'b0, slow = 1'b0;
    logic hasPrefix = 1'b0, rmwOp = 1'b0, setOp = 1'b0, clrOp = 1'b0;
    logic [3:0] baseMode = 4'h0;
    logic [7:0] prefixByte = 8'h00, idxX = 8'hFF, idxY = 8'h10;
    logic [15:0] pcIn = 16'h1234;
    logic memReq, memAck, done, modeError, isImmediate;
    logic [15:0] memAddr, effAddr;
    logic [7:0] memRdata, immValue;
    logic [3:0] effMode;
    logic [2:0] instrLen;
    logic [1:0] intMask;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    always #4 refClk = ~refClk;
    amd_decoder amd_decoder_inst (.refClk(refClk), .arst_n(arst_n),
        .start(start), .baseMode(baseMode), .prefixByte(prefixByte),
        .hasPrefix(hasPrefix), .rmwOp(rmwOp), .interruptMaskSetOp(setOp),
        .interruptMaskClearOp(clrOp), .pcIn(pcIn), .idxX(idxX),
        .idxY(idxY), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memRdata(memRdata), .done(done), .modeError(modeError),
        .effMode(effMode), .effAddr(effAddr), .immValue(immValue),
        .isImmediate(isImmediate), .instrLen(instrLen), .intMask(intMask));
    amd_mem_model amd_mem_model_inst (.refClk(refClk), .arst_n(arst_n),
        .slow(slow), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memRdata(memRdata));
    function automatic logic [7:0] mc(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hC3;
    endfunction
    function automatic logic [15:0] ea(input logic [3:0] m,
            input logic [7:0] ix);
        logic [7:0] b, q;
        logic [15:0] d, w;
        b = mc(pcIn + 16'h0001);
        q = mc({8'h00, b});
        d = {b, mc(pcIn + 16'h0002)};
        w = {q, mc({8'h00, b} + 16'h0001)};
        case (m)
            amd_pkg::MD_DIR_S: return {8'h00, b};
            amd_pkg::MD_DIR_L: return d;
            amd_pkg::MD_IDX_0: return {8'h00, ix};
            amd_pkg::MD_IDX_S: return {7'h00, {1'b0, b} + {1'b0, ix}};
            amd_pkg::MD_IDX_L: return d + {8'h00, ix};
            amd_pkg::MD_IND_S: return {8'h00, q};
            amd_pkg::MD_IND_L: return w;
            amd_pkg::MD_IIX_S: return {7'h00, {1'b0, q} + {1'b0, ix}};
            amd_pkg::MD_IIX_L: return w + {8'h00, ix};
            amd_pkg::MD_REL_D: return pcIn + 16'h0002 + {{8{b[7]}}, b};
            default: return pcIn + 16'h0002 + {{8{q[7]}}, q};
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Returns at the falling edge where done shows
    task automatic op(input logic [3:0] m, input logic [7:0] pf,
            input logic rmw);
        @(negedge refClk);
        baseMode = m;
        prefixByte = pf;
        hasPrefix = (pf != 8'h00);
        rmwOp = rmw;
        start = 1'b1;
        @(negedge refClk);
        start = 1'b0;
        for (int n = 0; n < 40 && done !== 1'b1; n++)
            @(negedge refClk);
        chk({15'h0, done}, 16'h0001);
    endtask
    task automatic xop(input logic [3:0] m, input logic [7:0] pf,
            input logic [3:0] em, input logic [2:0] len);
        logic [7:0] ix;
        ix = (pf == 8'h90 || pf == 8'h91) ? idxY : idxX;
        op(m, pf, 1'b0);
        chk({12'h0, effMode}, {12'h0, em});
        chk({13'h0, instrLen}, {13'h0, len});
        chk({15'h0, modeError}, 16'h0000);
        if (em > amd_pkg::MD_IMM)
            chk(effAddr, ea(em, ix));
    endtask
    task automatic sc_mask();
        chk({14'h0, intMask}, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            setOp = i[0];
            clrOp = (i != 1);
            xop(amd_pkg::MD_INH, 8'h00, amd_pkg::MD_INH, 3'h1);
            @(negedge refClk);
            chk({14'h0, intMask}, i[0] ? 16'h0003 : 16'h0000);
        end
        setOp = 1'b0;
        clrOp = 1'b0;
    endtask
    task automatic sc_imm();
        xop(amd_pkg::MD_IMM, 8'h00, amd_pkg::MD_IMM, 3'h2);
        chk({8'h00, immValue}, {8'h00, mc(pcIn + 16'h0001)});
        chk({15'h0, isImmediate}, 16'h0001);
    endtask
    task automatic sc_dir_idx();
        xop(amd_pkg::MD_DIR_S, 8'h00, amd_pkg::MD_DIR_S, 3'h2);
        xop(amd_pkg::MD_DIR_L, 8'h00, amd_pkg::MD_DIR_L, 3'h3);
        xop(amd_pkg::MD_IDX_0, 8'h00, amd_pkg::MD_IDX_0, 3'h1);
        xop(amd_pkg::MD_IDX_S, 8'h00, amd_pkg::MD_IDX_S, 3'h2);
        pcIn = 16'h003B;
        xop(amd_pkg::MD_IDX_L, 8'h00, amd_pkg::MD_IDX_L, 3'h3);
    endtask
    task automatic sc_ind();
        slow = 1'b1;
        pcIn = 16'h2041;
        xop(amd_pkg::MD_IND_S, 8'h00, amd_pkg::MD_IND_S, 3'h2);
        xop(amd_pkg::MD_IND_L, 8'h00, amd_pkg::MD_IND_L, 3'h2);
        xop(amd_pkg::MD_IIX_S, 8'h00, amd_pkg::MD_IIX_S, 3'h2);
        xop(amd_pkg::MD_IIX_L, 8'h00, amd_pkg::MD_IIX_L, 3'h2);
        slow = 1'b0;
        xop(amd_pkg::MD_REL_D, 8'h00, amd_pkg::MD_REL_D, 3'h2);
        xop(amd_pkg::MD_REL_I, 8'h00, amd_pkg::MD_REL_I, 3'h2);
    endtask
    task automatic sc_prefix();
        xop(amd_pkg::MD_IDX_S, 8'h90, amd_pkg::MD_IDX_S, 3'h3);
        xop(amd_pkg::MD_DIR_S, 8'h92, amd_pkg::MD_IND_S, 3'h3);
        xop(amd_pkg::MD_IDX_L, 8'h92, amd_pkg::MD_IIX_L, 3'h3);
        xop(amd_pkg::MD_IDX_S, 8'h91, amd_pkg::MD_IIX_S, 3'h3);
        xop(amd_pkg::MD_REL_D, 8'h92, amd_pkg::MD_REL_I, 3'h3);
    endtask
    task automatic sc_rmw();
        op(amd_pkg::MD_DIR_L, 8'h00, 1'b1);
        chk({15'h0, modeError}, 16'h0001);
        op(amd_pkg::MD_IDX_S, 8'h00, 1'b1);
        chk({15'h0, modeError}, 16'h0000);
        chk(effAddr, ea(amd_pkg::MD_IDX_S, idxX));
    endtask
    initial begin
        repeat (10) @(negedge refClk);
        arst_n = 1'b1;
        sc_mask();
        sc_imm();
        sc_dir_idx();
        sc_ind();
        sc_prefix();
        sc_rmw();
        end_sim();
    end
    always @(posedge refClk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end
endmodule
bind amd_decoder amd_asserts amd_asserts_inst (.refClk(refClk),
    .arst_n(arst_n), .start(start), .baseMode(baseMode),
    .hasPrefix(hasPrefix), .rmwOp(rmwOp), .pcIn(pcIn), .idxX(idxX),
    .interruptMaskSetOp(interruptMaskSetOp), .memReq(memReq),
    .interruptMaskClearOp(interruptMaskClearOp), .memAddr(memAddr),
    .memAck(memAck), .done(done), .modeError(modeError), .effMode(effMode),
    .effAddr(effAddr), .instrLen(instrLen), .intMask(intMask));
`default_nettype wire
